// >>> core/uie_pkg.sv
// package: register map, field positions, source codes and timing for the uart interrupt block
package uie_pkg;
  // ===========================================================
  // register addresses (a2..a0)
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_MASK = 3'h1;
  localparam logic [2:0] ADDR_SRC = 3'h2;
  localparam logic [2:0] ADDR_EFC = 3'h2;
  localparam logic [2:0] ADDR_LCTL = 3'h3;
  localparam logic [2:0] ADDR_LSTAT = 3'h5;
  localparam logic [2:0] ADDR_MSTAT = 3'h6;
  localparam logic [2:0] ADDR_RES1 = 3'h4;
  localparam logic [2:0] ADDR_RES2 = 3'h5;
  localparam logic [2:0] ADDR_PAU1 = 3'h6;
  localparam logic [2:0] ADDR_PAU2 = 3'h7;
  // ===========================================================
  // field positions and values
  localparam logic [7:0] LCTL_ENH = 8'hBF;
  localparam int EFC_GATE = 4;
  localparam int EFC_ARTS = 6;
  localparam int EFC_ACTS = 7;
  localparam int LCTL_DIV = 7;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MASK_ALWAYS = 8'h0F;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ===========================================================
  // source codes, priority 1 first
  localparam logic [5:0] SRC_LINE = 6'h06;
  localparam logic [5:0] SRC_TMO = 6'h0C;
  localparam logic [5:0] SRC_RXR = 6'h04;
  localparam logic [5:0] SRC_TXR = 6'h02;
  localparam logic [5:0] SRC_MDM = 6'h00;
  localparam logic [5:0] SRC_PAUSE = 6'h10;
  localparam logic [5:0] SRC_FLOW = 6'h20;
  localparam logic [5:0] SRC_NONE = 6'h01;
  // ===========================================================
  // receive timeout: four characters plus twelve bits
  localparam int TMO_CHARS = 4;
  localparam int TMO_BITS = 12;
endpackage : uie_pkg

// >>> core/uie_ctrl.sv
// uart interrupt enable, priority and status block
`timescale 1ns/1ps
`default_nettype none
module uie_ctrl
  import uie_pkg::*;
#(
  parameter int BIT_CYCLES = 16
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] addr,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic fifo_en,
  input wire logic rx_at_trigger,
  input wire logic rx_nonempty,
  input wire logic rx_push,
  input wire logic rx_overrun,
  input wire logic [2:0] rx_head_err,
  input wire logic rx_any_err,
  input wire logic tx_below_trigger,
  input wire logic tx_hold_empty,
  input wire logic tx_all_empty,
  input wire logic [3:0] modem_delta,
  input wire logic [3:0] modem_lines,
  input wire logic pause_seen,
  input wire logic resume_seen,
  input wire logic rts_rise,
  input wire logic cts_pin,
  input wire logic bit_tick,
  input wire logic [1:0] word_len,
  input wire logic sleep_exit,
  output logic irq,
  output logic sleep_en,
  output logic auto_rts,
  output logic auto_cts,
  output logic gate_on
);
  import uie_pkg::*;

  initial
  begin
    if (BIT_CYCLES < 1)
      $error("BIT_CYCLES must be at least one");
  end

  // ===========================================================
  // register bus
  logic [7:0] mask_r;
  logic [7:0] lctl_r;
  logic [7:0] efc_r;
  logic [7:0] res1_r;
  logic [7:0] res2_r;
  logic [7:0] pau1_r;
  logic [7:0] pau2_r;
  logic enh_sel;
  logic std_sel;
  logic wr_mask;
  logic rd_src;
  logic rd_lstat;
  logic rd_mstat;
  logic rd_hold;
  logic wr_hold;
  logic [5:0] irq_code;
  logic any_pend;

  assign enh_sel = (lctl_r == LCTL_ENH);
  assign std_sel = !lctl_r[LCTL_DIV];
  assign wr_mask = wr_stb && std_sel && addr == ADDR_MASK;
  assign rd_src = rd_stb && !enh_sel && addr == ADDR_SRC;
  assign rd_lstat = rd_stb && !enh_sel && addr == ADDR_LSTAT;
  assign rd_mstat = rd_stb && !enh_sel && addr == ADDR_MSTAT;
  assign rd_hold = rd_stb && std_sel && addr == ADDR_HOLD;
  assign wr_hold = wr_stb && std_sel && addr == ADDR_HOLD;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      lctl_r <= BYTE_ZERO;
    else if (wr_stb && addr == ADDR_LCTL)
      lctl_r <= wdata;
  end

  // upper mask bits only move while the gate is set, else they keep their value
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      mask_r <= MASK_RESET;
    else if (wr_mask)
    begin
      if (efc_r[EFC_GATE])
        mask_r <= wdata;
      else
        mask_r <= (wdata & MASK_ALWAYS) | (mask_r & ~MASK_ALWAYS);
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      efc_r <= BYTE_ZERO;
      res1_r <= BYTE_ZERO;
      res2_r <= BYTE_ZERO;
      pau1_r <= BYTE_ZERO;
      pau2_r <= BYTE_ZERO;
    end
    else if (wr_stb && enh_sel)
    begin
      if (addr == ADDR_EFC)
        efc_r <= wdata;
      else if (addr == ADDR_RES1)
        res1_r <= wdata;
      else if (addr == ADDR_RES2)
        res2_r <= wdata;
      else if (addr == ADDR_PAU1)
        pau1_r <= wdata;
      else if (addr == ADDR_PAU2)
        pau2_r <= wdata;
    end
  end

  // ===========================================================
  // sticky sources
  logic line_evt;
  logic tmo_r;
  logic txr_r;
  logic pause_r;
  logic flow_r;
  logic wake_r;
  logic cts_s1;
  logic cts_s2;
  logic cts_s3;
  logic hold_empty_d;
  logic below_d;
  logic [7:0] lstat;

  assign lstat = {rx_any_err, tx_all_empty, tx_hold_empty, rx_head_err, rx_overrun,
                  rx_nonempty};
  assign line_evt = |lstat[4:1];

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cts_s1 <= 1'b0;
      cts_s2 <= 1'b0;
      cts_s3 <= 1'b0;
    end
    else
    begin
      cts_s1 <= cts_pin;
      cts_s2 <= cts_s1;
      cts_s3 <= cts_s2;
    end
  end

  // set wins over clear in every sticky flag except tmo_r, where a holding read or empty fifo wins over the set
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      txr_r <= 1'b0;
      hold_empty_d <= 1'b0;
      below_d <= 1'b0;
    end
    else
    begin
      hold_empty_d <= tx_hold_empty;
      below_d <= tx_below_trigger;
      // fifo mode fires on the fall below trigger, not on the holding edge
      if (fifo_en ? (tx_below_trigger && !below_d) : (tx_hold_empty && !hold_empty_d))
        txr_r <= 1'b1;
      else if (wr_mask && wdata[1] && !mask_r[1] && tx_hold_empty)
        txr_r <= 1'b1;
      else if ((rd_src && irq_code == SRC_TXR) || wr_hold)
        txr_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      pause_r <= 1'b0;
    else if (pause_seen)
      pause_r <= 1'b1;
    else if ((rd_src && irq_code == SRC_PAUSE) || resume_seen)
      pause_r <= 1'b0;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      flow_r <= 1'b0;
    else if ((rts_rise && efc_r[EFC_ARTS]) ||
             (cts_s2 && !cts_s3 && efc_r[EFC_ACTS]))
      flow_r <= 1'b1;
    else if (rd_mstat)
      flow_r <= 1'b0;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      wake_r <= 1'b0;
    else if (sleep_exit && sleep_en)
      wake_r <= 1'b1;
    else if (rd_src)
      wake_r <= 1'b0;
  end

  // ===========================================================
  // receive timeout: restarts on any push or holding read
  localparam int TMO_W = 16;
  logic [TMO_W-1:0] tmo_cnt_r;
  logic [TMO_W-1:0] tmo_lim;
  logic [3:0] char_bits;

  assign char_bits = 4'(7 + int'(word_len)); // start, data, parity-free stop
  assign tmo_lim = TMO_W'(TMO_CHARS * int'(char_bits) + TMO_BITS);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tmo_cnt_r <= '0;
      tmo_r <= 1'b0;
    end
    else if (rx_push || rd_hold || !rx_nonempty || rx_at_trigger || !fifo_en)
    begin
      tmo_cnt_r <= '0;
      if (rd_hold || !rx_nonempty)
        tmo_r <= 1'b0;
    end
    else if (bit_tick)
    begin
      if (tmo_cnt_r + 1'b1 >= tmo_lim)
        tmo_r <= 1'b1;
      else
        tmo_cnt_r <= tmo_cnt_r + 1'b1;
    end
  end

  // ===========================================================
  // priority encoder and outputs
  logic rxr_live;

  assign rxr_live = fifo_en ? rx_at_trigger : rx_nonempty;

  always_comb
  begin
    irq_code = SRC_NONE;
    if (mask_r[2] && line_evt)
      irq_code = SRC_LINE;
    else if (mask_r[0] && tmo_r)
      irq_code = SRC_TMO;
    else if (mask_r[0] && rxr_live)
      irq_code = SRC_RXR;
    else if (mask_r[1] && txr_r)
      irq_code = SRC_TXR;
    else if (mask_r[3] && |modem_delta)
      irq_code = SRC_MDM;
    else if (mask_r[5] && pause_r && efc_r[EFC_GATE])
      irq_code = SRC_PAUSE;
    else if ((mask_r[6] || mask_r[7]) && flow_r && efc_r[EFC_GATE])
      irq_code = SRC_FLOW;
  end

  assign any_pend = (irq_code != SRC_NONE);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq <= 1'b0;
      sleep_en <= 1'b0;
      auto_rts <= 1'b0;
      auto_cts <= 1'b0;
      gate_on <= 1'b0;
    end
    else
    begin
      irq <= any_pend;
      sleep_en <= mask_r[4] && efc_r[EFC_GATE];
      auto_rts <= efc_r[EFC_ARTS];
      auto_cts <= efc_r[EFC_ACTS];
      gate_on <= efc_r[EFC_GATE];
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdata <= BYTE_ZERO;
    else if (rd_stb)
    begin
      if (enh_sel && addr == ADDR_EFC)
        rdata <= efc_r;
      else if (enh_sel && addr == ADDR_RES1)
        rdata <= res1_r;
      else if (enh_sel && addr == ADDR_RES2)
        rdata <= res2_r;
      else if (enh_sel && addr == ADDR_PAU1)
        rdata <= pau1_r;
      else if (enh_sel && addr == ADDR_PAU2)
        rdata <= pau2_r;
      else if (addr == ADDR_LCTL)
        rdata <= lctl_r;
      else if (std_sel && addr == ADDR_MASK)
        rdata <= efc_r[EFC_GATE] ? mask_r : (mask_r & MASK_ALWAYS);
      else if (addr == ADDR_SRC)
        rdata <= {fifo_en, fifo_en, wake_r && !any_pend ? SRC_NONE : irq_code};
      else if (addr == ADDR_LSTAT)
        rdata <= lstat;
      else if (addr == ADDR_MSTAT)
        rdata <= {modem_lines, modem_delta};
      else
        rdata <= BYTE_ZERO;
    end
  end

  // ===========================================================
  // checks
  reset_mask_a: assert property (@(posedge mclk) $rose(resetn) |-> mask_r == MASK_RESET)
    else $error("mask not clear after reset");
  irq_follow_a: assert property (@(posedge mclk) disable iff (!resetn)
    any_pend |=> irq) else $error("irq missed pending source");
  irq_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
    !any_pend |=> !irq) else $error("irq without source");
  line_prio_a: assert property (@(posedge mclk) disable iff (!resetn)
    mask_r[2] && line_evt |-> irq_code == SRC_LINE) else $error("line not first");
  rx_trig_a: assert property (@(posedge mclk) disable iff (!resetn)
    mask_r[0] && fifo_en && rx_at_trigger && !line_evt && !tmo_r |-> irq_code == SRC_RXR)
    else $error("rx trigger code wrong");
  gate_mask_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr_mask && !efc_r[EFC_GATE] |=> mask_r[7:4] == $past(mask_r[7:4]))
    else $error("upper mask moved while locked");
  efc_lock_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr_stb && !enh_sel |=> efc_r == $past(efc_r)) else $error("efc written unlocked");
  txr_arm_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr_mask && wdata[1] && !mask_r[1] && tx_hold_empty && !wr_hold |=> txr_r)
    else $error("tx ready not raised on enable");
  wake_a: assert property (@(posedge mclk) disable iff (!resetn)
    sleep_exit && sleep_en |=> wake_r) else $error("wake indicator missed");
  mdm_a: assert property (@(posedge mclk) disable iff (!resetn)
    mask_r[3] && |modem_delta |-> any_pend) else $error("modem change lost");
  line_cov: cover property (@(posedge mclk) irq_code == SRC_LINE ##1 rd_lstat);
  tmo_cov: cover property (@(posedge mclk) tmo_r && mask_r[0]);
  flow_cov: cover property (@(posedge mclk) irq_code == SRC_FLOW);
endmodule : uie_ctrl
`default_nettype wire

// >>> tb/uie_line_model.sv
// far-side model of the serial core: bit-rate tick and the cts pin
`timescale 1ns/1ps
`default_nettype none
module uie_line_model #(
  parameter int TICK = 4
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cts_req,
  output logic bit_tick,
  output wire logic cts_pin
);
  int cnt_r;
  // ===========================================================
  // bit tick runs free, like a baud generator
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= 0;
      bit_tick <= 1'b0;
    end
    else
    begin
      cnt_r <= (cnt_r == TICK - 1) ? 0 : cnt_r + 1;
      bit_tick <= (cnt_r == TICK - 1);
    end
  end
  // ===========================================================
  // pin moves off the clock grid, as a remote transmitter would
  assign #7 cts_pin = cts_req;
endmodule : uie_line_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the uart interrupt enable and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uie_pkg::*;
  localparam int TICK = 4;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic rd_stb = 1'b0;
  logic wr_stb = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic fifo_en = 1'b0;
  logic rx_at_trigger = 1'b0;
  logic rx_nonempty = 1'b0;
  logic rx_push = 1'b0;
  logic rx_overrun = 1'b0;
  logic [2:0] rx_head_err = 3'h0;
  logic rx_any_err = 1'b0;
  logic tx_below_trigger = 1'b0;
  logic tx_hold_empty = 1'b0;
  logic tx_all_empty = 1'b0;
  logic [3:0] modem_delta = 4'h0;
  logic [3:0] modem_lines = 4'h0;
  logic pause_seen = 1'b0;
  logic resume_seen = 1'b0;
  logic rts_rise = 1'b0;
  logic cts_req = 1'b0;
  logic sleep_exit = 1'b0;
  logic [1:0] word_len = 2'h0;
  logic cts_pin, bit_tick, irq, sleep_en, auto_rts, auto_cts, gate_on;
  logic [7:0] vec [6] = '{8'h01, 8'h02, 8'h1C, 8'h60, 8'h80, 8'hA5};
  int errors = 0;
  int cmp_count = 0;

  always #10 mclk = ~mclk;

  uie_line_model #(.TICK(TICK)) line_u (.mclk(mclk), .resetn(resetn), .cts_req(cts_req),
    .bit_tick(bit_tick), .cts_pin(cts_pin));

  uie_ctrl #(.BIT_CYCLES(TICK)) dut_u (.mclk(mclk), .resetn(resetn), .addr(addr),
    .rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata), .rdata(rdata), .fifo_en(fifo_en),
    .rx_at_trigger(rx_at_trigger), .rx_nonempty(rx_nonempty), .rx_push(rx_push),
    .rx_overrun(rx_overrun), .rx_head_err(rx_head_err), .rx_any_err(rx_any_err),
    .tx_below_trigger(tx_below_trigger), .tx_hold_empty(tx_hold_empty),
    .tx_all_empty(tx_all_empty), .modem_delta(modem_delta), .modem_lines(modem_lines),
    .pause_seen(pause_seen), .resume_seen(resume_seen), .rts_rise(rts_rise),
    .cts_pin(cts_pin), .bit_tick(bit_tick), .word_len(word_len), .sleep_exit(sleep_exit),
    .irq(irq), .sleep_en(sleep_en), .auto_rts(auto_rts), .auto_cts(auto_cts),
    .gate_on(gate_on));

  // ===========================================================
  // access tasks; all drive 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_stb = 1'b1;
    cyc(1);
    wr_stb = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp, input string nm);
    addr = a;
    rd_stb = 1'b1;
    cyc(1);
    rd_stb = 1'b0;
    chk(nm, exp, rdata);
    cyc(1);
  endtask : rdchk

  task automatic close_out();
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // bounded wait; a missing interrupt ends the run
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++)
      cyc(1);
    if (irq !== 1'b1)
    begin
      errors++;
      close_out();
    end
  endtask : wait_irq

  // ===========================================================
  // main sequence
  initial
  begin
    cyc(5);
    resetn = 1'b1;
    cyc(1);
    rdchk(ADDR_MASK, MASK_RESET, "mask");
    rdchk(ADDR_SRC, {2'b00, SRC_NONE}, "src idle");
    chk("irq idle", 8'h00, {7'h00, irq});
    // upper enables stay locked while the gate is clear
    wr(ADDR_MASK, 8'hFF);
    rdchk(ADDR_MASK, MASK_ALWAYS, "mask locked");
    wr(ADDR_MASK, 8'h00);
    // polled mode: fifos on, low enables clear, status only
    fifo_en = 1'b1;
    foreach (vec[i])
    begin
      {rx_any_err, tx_all_empty, tx_hold_empty, rx_head_err, rx_overrun, rx_nonempty} = vec[i];
      cyc(2);
      rdchk(ADDR_LSTAT, vec[i], "line status");
      chk("irq polled", 8'h00, {7'h00, irq});
    end
    {rx_any_err, tx_all_empty, tx_hold_empty, rx_head_err, rx_overrun, rx_nonempty} = 8'h00;
    // three sources at once, then dropped one by one in priority order
    wr(ADDR_MASK, 8'h0F);
    rx_overrun = 1'b1;
    rx_at_trigger = 1'b1;
    modem_delta = 4'h1;
    cyc(2);
    chk("irq set", 8'h01, {7'h00, irq});
    rdchk(ADDR_SRC, {2'b11, SRC_LINE}, "src line");
    rx_overrun = 1'b0;
    cyc(2);
    rdchk(ADDR_SRC, {2'b11, SRC_RXR}, "src rx");
    rx_at_trigger = 1'b0;
    cyc(2);
    rdchk(ADDR_SRC, {2'b11, SRC_MDM}, "src modem");
    modem_delta = 4'h0;
    cyc(2);
    rdchk(ADDR_SRC, {2'b11, SRC_NONE}, "src clear");
    chk("irq clear", 8'h00, {7'h00, irq});
    // transmit ready raised at once when enabled on an empty holding
    wr(ADDR_MASK, 8'h00);
    tx_hold_empty = 1'b1;
    cyc(2);
    wr(ADDR_MASK, 8'h02);
    cyc(2);
    rdchk(ADDR_SRC, {2'b11, SRC_TXR}, "src tx");
    rdchk(ADDR_SRC, {2'b11, SRC_NONE}, "src tx read");
    tx_hold_empty = 1'b0;
    // timeout: 4 * (7 + word_len) + 12 ticks with data below trigger
    wr(ADDR_MASK, 8'h01);
    rx_nonempty = 1'b1;
    cyc(36 * TICK);
    chk("irq early", 8'h00, {7'h00, irq});
    wait_irq(10 * TICK);
    rdchk(ADDR_SRC, {2'b11, SRC_TMO}, "src timeout");
    rx_nonempty = 1'b0;
    rdchk(ADDR_HOLD, BYTE_ZERO, "hold read");
    cyc(1);
    rdchk(ADDR_SRC, {2'b11, SRC_NONE}, "src tmo clr");
    // enhanced access: gate, flow characters, upper enables
    wr(ADDR_LCTL, LCTL_ENH);
    wr(ADDR_EFC, 8'hD0);
    cyc(1);
    chk("gate", 8'h07, {5'h00, gate_on, auto_rts, auto_cts});
    for (int a = 4; a < 8; a++)
      wr(a[2:0], 8'h11 * a[7:0]);
    for (int a = 4; a < 8; a++)
      rdchk(a[2:0], 8'h11 * a[7:0], "flow char");
    wr(ADDR_LCTL, 8'h03);
    wr(ADDR_MASK, 8'hF0);
    rdchk(ADDR_MASK, 8'hF0, "mask open");
    chk("sleep on", 8'h01, {7'h00, sleep_en});
    sleep_exit = 1'b1;
    cyc(1);
    sleep_exit = 1'b0;
    cyc(1);
    rdchk(ADDR_SRC, {2'b11, SRC_NONE}, "src wake");
    wr(ADDR_MASK, 8'hE0);
    cyc(1);
    chk("sleep off", 8'h00, {7'h00, sleep_en});
    pause_seen = 1'b1;
    cyc(1);
    pause_seen = 1'b0;
    cyc(2);
    rdchk(ADDR_SRC, {2'b11, SRC_PAUSE}, "src pause");
    rdchk(ADDR_SRC, {2'b11, SRC_NONE}, "src pause clr");
    rts_rise = 1'b1;
    cyc(1);
    rts_rise = 1'b0;
    cyc(2);
    rdchk(ADDR_SRC, {2'b11, SRC_FLOW}, "src rts");
    rdchk(ADDR_MSTAT, BYTE_ZERO, "modem read");
    cyc(1);
    rdchk(ADDR_SRC, {2'b11, SRC_NONE}, "src rts clr");
    cts_req = 1'b1;
    wait_irq(12);
    rdchk(ADDR_SRC, {2'b11, SRC_FLOW}, "src cts");
    close_out();
  end
endmodule : testbench
`default_nettype wire
